/* File: logic/cms_pkg.sv */
// Constants and types for the core memory map and stack block.
package cms_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned RAM_BYTES = 256;
    localparam logic [16:0] SPACE_BYTES = 17'h10000;
    localparam logic [15:0] ONCHIP_CODE_TOP = 16'h2000;
    localparam logic [7:0] DIRECT_RAM_TOP = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] SCRATCH_BASE = 8'h30;
    localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
    localparam logic [7:0] MAIN_WORK_ADDR = 8'hE0;
    localparam logic [7:0] AUX_REG_ADDR = 8'hF0;
    localparam logic [7:0] THIRD_PORT_ADDR = 8'hB0;
    localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam logic [7:0] MAIN_WORK_RESET = 8'h00;
    localparam logic [7:0] AUX_REG_RESET = 8'h00;
    localparam logic [7:0] THIRD_PORT_RESET = 8'hFF;
    localparam logic [7:0] UNIMPL_READ_VALUE = 8'h00;
    localparam int unsigned BANK_LO_BIT = 3;
    localparam int unsigned BANK_HI_BIT = 4;
    localparam int unsigned OSC_PER_MACHINE_CYCLE = 12;
    localparam int unsigned RESET_HOLD_MC = 2;
    localparam logic [4:0] RESET_HOLD_CLKS = 5'(RESET_HOLD_MC * OSC_PER_MACHINE_CYCLE);
    localparam logic [3:0] PHASE_LAST = 4'(OSC_PER_MACHINE_CYCLE - 1);
    localparam logic [3:0] STROBE_A_START = 4'h3;
    localparam logic [3:0] STROBE_A_END = 4'h5;
    localparam logic [3:0] STROBE_B_START = 4'h9;
    localparam logic [3:0] STROBE_B_END = 4'hB;

    typedef enum logic [2:0] {
        CMS_DIRECT,
        CMS_INDIRECT,
        CMS_BANK_REG,
        CMS_BIT,
        CMS_PUSH,
        CMS_POP
    } cms_mode_e;
endpackage

/* File: logic/cms_memmap.sv */
// Internal data memory, peripheral register window, stack pointer, reset qualifier and fetch strobe.
module cms_memmap
    import cms_pkg::*;
#(
    parameter bit ROM_PRESENT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic req_valid,
    input wire logic req_write,
    input wire cms_mode_e req_mode,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    input wire logic aux_load,
    input wire logic [7:0] aux_load_data,
    output logic [7:0] aux_value,
    output logic [7:0] main_work_value,
    output logic [7:0] stack_pointer,
    output logic [1:0] active_bank,
    output logic core_reset,
    input wire logic fetch_active,
    input wire logic [15:0] fetch_pc,
    input wire logic xdata_cycle,
    input wire logic ext_code_only_pin,
    output logic program_fetch_strobe_n,
    input wire logic [7:0] third_io_port_in,
    input wire logic [7:0] third_io_port_alt_out,
    output logic [7:0] third_io_port_out,
    output logic [7:0] third_io_port_oe,
    output logic serial_in,
    output logic ext_irq_zero,
    output logic ext_irq_one,
    output logic timer_zero_input,
    output logic timer_one_input
);

    typedef struct packed {
        logic [7:0] stk_ptr;
        logic [7:0] status_word;
        logic [7:0] main_work;
        logic [7:0] aux;
        logic [7:0] port_latch;
        logic [7:0] port_s1;
        logic [7:0] port_s2;
        logic [7:0] port_oe;
        logic [7:0] port_out;
        logic rst_s1;
        logic rst_s2;
        logic [4:0] rst_cnt;
        logic core_reset;
        logic ext_s1;
        logic ext_s2;
        logic [3:0] phase;
        logic strobe_n;
        logic rsp_valid;
        logic [7:0] rsp_rdata;
    } cms_state_s;

    localparam cms_state_s STATE_RESET = '{
        stk_ptr: STACK_POINTER_RESET,
        status_word: STATUS_WORD_RESET,
        main_work: MAIN_WORK_RESET,
        aux: AUX_REG_RESET,
        port_latch: THIRD_PORT_RESET,
        port_s1: 8'hFF,
        port_s2: 8'hFF,
        port_oe: 8'h00,
        port_out: 8'h00,
        rst_s1: 1'b0,
        rst_s2: 1'b0,
        rst_cnt: 5'h00,
        core_reset: 1'b0,
        ext_s1: 1'b0,
        ext_s2: 1'b0,
        phase: 4'h0,
        strobe_n: 1'b1,
        rsp_valid: 1'b0,
        rsp_rdata: 8'h00
    };

    cms_state_s st;
    cms_state_s next_st;
    logic [7:0] ram [RAM_BYTES];
    logic ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [7:0] tgt;
    logic tgt_periph;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    logic do_write;
    logic code_onchip;
    logic strobe_slot;

    // Working register n of the bank named by the status word.
    function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank, input logic [2:0] n);
        return {3'b000, bank, n};
    endfunction

    // Byte that holds a bit address: low half maps onto the bit area, high half onto peripheral registers.
    function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
        if (bit_addr[7]) begin
            return {bit_addr[7:3], 3'b000};
        end
        return BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
    endfunction

    // Unoccupied peripheral addresses read back a fixed value; software must not rely on it.
    function automatic logic [7:0] periph_read(input logic [7:0] a, input cms_state_s s);
        case (a)
            STACK_POINTER_ADDR: return s.stk_ptr;
            STATUS_WORD_ADDR: return s.status_word;
            MAIN_WORK_ADDR: return s.main_work;
            AUX_REG_ADDR: return s.aux;
            THIRD_PORT_ADDR: return s.port_s2;
            default: return UNIMPL_READ_VALUE;
        endcase
    endfunction

    function automatic logic in_strobe_slot(input logic [3:0] ph);
        return (ph >= STROBE_A_START && ph <= STROBE_A_END) || (ph >= STROBE_B_START && ph <= STROBE_B_END);
    endfunction

    // Functional notes
    // RQ1: Program and data spaces are separate, each up to 64K bytes.
    // RQ2: Lowest 8K of program space may come from on-chip storage; rest external.
    // RQ3: 256 bytes of internal RAM; lower 128 reachable directly and indirectly.
    // RQ4: Upper 128 RAM bytes reachable only indirectly.
    // RQ5: Bytes 00H-1FH are four banks of eight working registers.
    // RQ6: Reset selects bank zero; software selects other banks.
    // RQ7: Bytes 20H-2FH also addressable as 128 bits, bit addresses 0-7FH.
    // RQ8: Bytes 30H-7FH are plain scratch RAM.
    // RQ9: Direct addresses 80H-FFH select the peripheral register space.
    // RQ10: Writes to unoccupied peripheral addresses change nothing; reads undefined.
    // RQ11: Software should not write ones to unoccupied peripheral addresses.
    // RQ12: Eight-bit stack pointer increments before each stack write.
    // RQ13: Reset loads stack pointer 07H, so the first push lands at 08H.
    // RQ14: Reset pin must stay high two machine cycles to reset the core.
    // RQ15: External fetch strobe pulses twice per machine cycle; skipped during data access.
    // RQ16: Fetch strobe stays inactive for on-chip program fetches.
    // RQ17: Third port pins are quasi-bidirectional; a one lets the pin be an input.
    // RQ18: Third port alternate functions: serial, interrupts, timers, data strobes.
    // RQ19: Auxiliary register holds multiply/divide operands, else general scratch.
    // RQ20: A machine cycle is twelve oscillator periods.

    // Internal data RAM is 256 bytes, external data accesses show only as xdata_cycle; program space size is fixed by the 16-bit fetch address.
    assign code_onchip = ROM_PRESENT && !st.ext_s2 && (fetch_pc < ONCHIP_CODE_TOP); // RQ1 RQ2
    assign strobe_slot = in_strobe_slot(st.phase);

    always_comb begin
        next_st = st;
        tgt = req_addr;
        tgt_periph = 1'b0;
        do_write = req_write;
        case (req_mode)
            CMS_DIRECT: begin
                tgt_periph = req_addr[7]; // RQ3 RQ4 RQ9
            end
            CMS_INDIRECT: begin
                tgt_periph = 1'b0; // RQ3 RQ4
            end
            CMS_BANK_REG: begin
                tgt = bank_reg_addr(st.status_word[BANK_HI_BIT:BANK_LO_BIT], req_addr[2:0]); // RQ5
            end
            CMS_BIT: begin
                tgt = bit_byte_addr(req_addr); // RQ7
                tgt_periph = req_addr[7];
            end
            CMS_PUSH: begin
                tgt = st.stk_ptr + 8'h01; // RQ12
                do_write = 1'b1;
            end
            CMS_POP: begin
                tgt = st.stk_ptr;
                do_write = 1'b0;
            end
            default: begin
                do_write = 1'b0;
            end
        endcase
        do_write = do_write && req_valid && !st.core_reset;
        old_byte = tgt_periph ? periph_read(tgt, st) : ram[tgt];
        new_byte = req_wdata;
        if (req_mode == CMS_BIT) begin
            new_byte = old_byte;
            new_byte[req_addr[2:0]] = req_wdata[0]; // RQ7
        end
        // Bytes 30H-7FH need no special handling: they are ordinary RAM. RQ8
        ram_we = do_write && !tgt_periph; // RQ4
        ram_waddr = tgt;
        ram_wdata = new_byte;

        next_st.rsp_valid = req_valid && !st.core_reset;
        next_st.rsp_rdata = (req_mode == CMS_BIT) ? {7'h00, old_byte[req_addr[2:0]]} : old_byte;

        if (aux_load) begin
            next_st.aux = aux_load_data; // RQ19
        end
        if (do_write && tgt_periph) begin
            case (tgt)
                STACK_POINTER_ADDR: next_st.stk_ptr = new_byte;
                STATUS_WORD_ADDR: next_st.status_word = new_byte; // RQ6
                MAIN_WORK_ADDR: next_st.main_work = new_byte;
                AUX_REG_ADDR: next_st.aux = new_byte; // RQ19
                THIRD_PORT_ADDR: next_st.port_latch = new_byte;
                default: next_st.stk_ptr = st.stk_ptr; // RQ10 RQ11
            endcase
        end
        if (req_valid && !st.core_reset && req_mode == CMS_PUSH) begin
            next_st.stk_ptr = st.stk_ptr + 8'h01; // RQ12
        end
        if (req_valid && !st.core_reset && req_mode == CMS_POP) begin
            next_st.stk_ptr = st.stk_ptr - 8'h01;
        end

        // A zero latch pulls the pin low; a one, with a one on the alternate output, leaves it to the pull-up so the pin can be read. RQ17 RQ18
        next_st.port_s1 = third_io_port_in;
        next_st.port_s2 = st.port_s1;
        next_st.port_oe = ~(st.port_latch & third_io_port_alt_out);

        // Reset pin is counted in oscillator clocks, so a glitch shorter than two machine cycles is ignored.
        next_st.rst_s1 = reset_pin;
        next_st.rst_s2 = st.rst_s1;
        next_st.ext_s1 = ext_code_only_pin;
        next_st.ext_s2 = st.ext_s1;
        if (!st.rst_s2) begin
            next_st.rst_cnt = 5'h00;
            next_st.core_reset = 1'b0;
        end else if (st.rst_cnt < RESET_HOLD_CLKS - 5'h01) begin
            next_st.rst_cnt = st.rst_cnt + 5'h01;
        end else begin
            next_st.core_reset = 1'b1; // RQ14
        end

        next_st.phase = (st.phase == PHASE_LAST) ? 4'h0 : st.phase + 4'h1; // RQ20
        next_st.strobe_n = !(fetch_active && !code_onchip && !xdata_cycle && strobe_slot); // RQ15 RQ16

        if (st.core_reset) begin
            next_st.stk_ptr = STACK_POINTER_RESET; // RQ13
            next_st.status_word = STATUS_WORD_RESET; // RQ6
            next_st.main_work = MAIN_WORK_RESET;
            next_st.aux = AUX_REG_RESET;
            next_st.port_latch = THIRD_PORT_RESET;
            next_st.phase = 4'h0;
            next_st.strobe_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // RAM contents are not cleared by reset, matching a real on-chip array.
    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

    assign rsp_valid = st.rsp_valid;
    assign rsp_rdata = st.rsp_rdata;
    assign aux_value = st.aux;
    assign main_work_value = st.main_work;
    assign stack_pointer = st.stk_ptr;
    assign active_bank = st.status_word[BANK_HI_BIT:BANK_LO_BIT];
    assign core_reset = st.core_reset;
    assign program_fetch_strobe_n = st.strobe_n;
    assign third_io_port_out = st.port_out;
    assign third_io_port_oe = st.port_oe;
    assign serial_in = st.port_s2[0];
    assign ext_irq_zero = st.port_s2[2];
    assign ext_irq_one = st.port_s2[3];
    assign timer_zero_input = st.port_s2[4];
    assign timer_one_input = st.port_s2[5];

    a_stack_after_reset: assert property (@(posedge core_clk) disable iff (rst) // RQ13
        st.core_reset |=> st.stk_ptr == STACK_POINTER_RESET)
        else $error("Stack pointer not 07H after reset.");
    a_bank_after_reset: assert property (@(posedge core_clk) disable iff (rst) // RQ6
        st.core_reset |=> st.status_word[BANK_HI_BIT:BANK_LO_BIT] == 2'h0)
        else $error("Bank not zero after reset.");
    a_push_order: assert property (@(posedge core_clk) disable iff (rst) // RQ12
        (req_valid && !st.core_reset && req_mode == CMS_PUSH)
        |=> (st.stk_ptr == $past(st.stk_ptr) + 8'h01) && (ram[st.stk_ptr] == $past(req_wdata)))
        else $error("Push did not pre-increment.");
    a_pop_order: assert property (@(posedge core_clk) disable iff (rst) // RQ12
        (req_valid && !st.core_reset && req_mode == CMS_POP) |=> (st.stk_ptr == $past(st.stk_ptr) - 8'h01) && rsp_valid)
        else $error("Pop did not decrement.");
    a_pop_data: assert property (@(posedge core_clk) disable iff (rst) // RQ12
        (req_valid && !st.core_reset && req_mode == CMS_POP) |=> rsp_rdata == ram[st.stk_ptr + 8'h01])
        else $error("Pop returned the wrong byte.");
    a_direct_no_ram: assert property (@(posedge core_clk) disable iff (rst) // RQ4
        (req_valid && req_mode == CMS_DIRECT && req_addr[7]) |-> !ram_we)
        else $error("Direct upper address wrote RAM.");
    a_indirect_ram: assert property (@(posedge core_clk) disable iff (rst) // RQ3 RQ4
        (req_valid && req_write && !st.core_reset && req_mode == CMS_INDIRECT)
        |-> ram_we && ram_waddr == req_addr)
        else $error("Indirect write missed RAM.");
    a_bank_select: assert property (@(posedge core_clk) disable iff (rst) // RQ5
        (req_valid && req_write && !st.core_reset && req_mode == CMS_BANK_REG)
        |-> ram_we && ram_waddr == {3'h0, active_bank, req_addr[2:0]})
        else $error("Working register outside active bank.");
    a_bit_area: assert property (@(posedge core_clk) disable iff (rst) // RQ7
        (req_valid && req_write && !st.core_reset && req_mode == CMS_BIT && !req_addr[7])
        |-> ram_we && ram_waddr[7:4] == 4'h2)
        else $error("Bit write outside the bit area.");
    // One unoccupied address stands for all of them; listing every hole would need a table here.
    a_unimpl_write: assert property (@(posedge core_clk) disable iff (rst) // RQ10
        (req_valid && req_write && !st.core_reset && !aux_load && req_mode == CMS_DIRECT && req_addr == 8'h85)
        |=> $stable(st.stk_ptr) && $stable(st.status_word) && $stable(st.main_work) && $stable(st.aux)
            && $stable(st.port_latch))
        else $error("Unoccupied write changed state.");
    a_short_reset: assert property (@(posedge core_clk) disable iff (rst) // RQ14
        (!st.rst_s2 ##1 st.rst_s2 [*8]) |-> !st.core_reset)
        else $error("Short reset pulse reset the core.");
    a_reset_qualify: assert property (@(posedge core_clk) disable iff (rst) // RQ14 RQ20
        $rose(st.core_reset) |-> $past(st.rst_s2) && $past(st.rst_cnt) == RESET_HOLD_CLKS - 5'h01)
        else $error("Core reset without full hold.");
    a_reset_blocks: assert property (@(posedge core_clk) disable iff (rst) // RQ14
        st.core_reset |-> !ram_we)
        else $error("RAM written during core reset.");
    a_rsp_idle: assert property (@(posedge core_clk) disable iff (rst) // RQ3
        !req_valid |=> !rsp_valid)
        else $error("Answer without request.");
    a_phase_range: assert property (@(posedge core_clk) disable iff (rst) // RQ20
        st.phase <= PHASE_LAST)
        else $error("Machine cycle phase out of range.");
    a_strobe_onchip: assert property (@(posedge core_clk) disable iff (rst) // RQ16
        (fetch_active && code_onchip) |=> program_fetch_strobe_n)
        else $error("Strobe active on on-chip fetch.");
    a_strobe_xdata: assert property (@(posedge core_clk) disable iff (rst) // RQ15
        xdata_cycle |=> program_fetch_strobe_n)
        else $error("Strobe active during data access.");
    a_strobe_pulse: assert property (@(posedge core_clk) disable iff (rst) // RQ15 RQ20
        (st.phase == 4'h3 && !st.core_reset && fetch_active && !code_onchip && !xdata_cycle) |=> !program_fetch_strobe_n)
        else $error("Strobe pulse missing.");
    a_strobe_phase: assert property (@(posedge core_clk) disable iff (rst) // RQ15 RQ20
        !program_fetch_strobe_n |-> st.phase inside {4'h4, 4'h5, 4'h6, 4'hA, 4'hB, 4'h0})
        else $error("Strobe low outside its slots.");

endmodule

/* File: test/cms_prog_mem.sv */
// External program memory model that watches the fetch strobe and presents code bytes.
module cms_prog_mem
    import cms_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic strobe_n,
    output logic [7:0] code_byte,
    output logic [15:0] pulse_count,
    output logic [3:0] low_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_n;
    logic [3:0] run;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_n <= 1'h1;
            pulse_count <= 16'h0000;
            run <= 4'h0;
            low_len <= 4'h0;
            code_byte <= 8'hA5;
        end else begin
            last_n <= strobe_n;
            if (!strobe_n && last_n) begin
                pulse_count <= pulse_count + 16'h0001;
            end
            if (!strobe_n) begin
                run <= run + 4'h1;
            end else if (!last_n) begin
                low_len <= run;
                run <= 4'h0;
            end
            // A released bus toggles so that a stale byte is never mistaken for a fetch.
            code_byte <= strobe_n ? ~code_byte : 8'h3C;
        end
    end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the memory map, stack pointer, reset qualifier and fetch strobe.
module testbench;
    import cms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        cms_mode_e mode;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
        logic [1:0] flags;
    } cms_row_s;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic reset_pin = 1'h0;
    logic req_valid = 1'h0;
    logic req_write = 1'h0;
    cms_mode_e req_mode = CMS_DIRECT;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    logic aux_load = 1'h0;
    logic [7:0] aux_load_data = 8'h00;
    logic fetch_active = 1'h0;
    logic [15:0] fetch_pc = 16'h0000;
    logic xdata_cycle = 1'h0;
    logic ext_code_only_pin = 1'h0;
    logic [7:0] alt_out = 8'hFF;
    logic [7:0] ext_low = 8'hEB;
    logic rsp_valid, core_reset, strobe_n, ser, irq0, irq1, tm0, tm1;
    logic [7:0] rsp_rdata, aux_value, main_work_value, stack_pointer, port_out, port_oe, code_byte;
    logic [1:0] active_bank;
    logic [15:0] pulse_count;
    logic [3:0] low_len;
    wire logic [7:0] pins = ~(ext_low | port_oe);
    int bad_count = 0;
    int n_checks = 0;
    cms_row_s rows[$];
    always #5 core_clk = ~core_clk;
    cms_memmap uut (.core_clk(core_clk), .rst(rst), .reset_pin(reset_pin), .req_valid(req_valid),
        .req_write(req_write), .req_mode(req_mode), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .aux_load(aux_load), .aux_load_data(aux_load_data),
        .aux_value(aux_value), .main_work_value(main_work_value), .stack_pointer(stack_pointer),
        .active_bank(active_bank), .core_reset(core_reset), .fetch_active(fetch_active), .fetch_pc(fetch_pc),
        .xdata_cycle(xdata_cycle), .ext_code_only_pin(ext_code_only_pin), .program_fetch_strobe_n(strobe_n),
        .third_io_port_in(pins), .third_io_port_alt_out(alt_out), .third_io_port_out(port_out),
        .third_io_port_oe(port_oe), .serial_in(ser), .ext_irq_zero(irq0), .ext_irq_one(irq1),
        .timer_zero_input(tm0), .timer_one_input(tm1));
    cms_prog_mem pmem (.core_clk(core_clk), .rst(rst), .strobe_n(strobe_n), .code_byte(code_byte),
        .pulse_count(pulse_count), .low_len(low_len));
    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic add(input cms_mode_e m, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
        input logic [1:0] f);
        rows.push_back('{m, a, d, e, f});
    endtask
    // The answer stands one cycle, so it is sampled at the falling edge inside that cycle.
    task automatic access(input cms_row_s r, output logic [7:0] q, output logic v);
        @(negedge core_clk);
        req_valid = 1'h1;
        req_mode = r.mode;
        req_write = r.flags[0];
        req_addr = r.addr;
        req_wdata = r.wdata;
        @(negedge core_clk);
        v = rsp_valid;
        q = rsp_rdata;
        req_valid = 1'h0;
        @(negedge core_clk);
    endtask
    task automatic strobe_run(input logic [15:0] pc, input logic xd, input logic pin, input logic [15:0] exp);
        logic [15:0] c0;
        @(negedge core_clk);
        fetch_active = 1'h1;
        fetch_pc = pc;
        xdata_cycle = xd;
        ext_code_only_pin = pin;
        repeat (16) @(negedge core_clk);
        c0 = pulse_count;
        repeat (48) @(negedge core_clk);
        check(pulse_count - c0, exp);
    endtask
    initial begin
        logic [7:0] q;
        logic v;
        int i;
        add(CMS_DIRECT, 8'h30, 8'hA5, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h30, 8'h00, 8'hA5, 2'h2);
        add(CMS_INDIRECT, 8'h90, 8'h3C, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h90, 8'h00, 8'h00, 2'h3);
        add(CMS_DIRECT, 8'h85, 8'h00, 8'h00, 2'h3);
        add(CMS_INDIRECT, 8'h90, 8'h00, 8'h3C, 2'h2);
        add(CMS_DIRECT, 8'h90, 8'h00, 8'h00, 2'h2);
        add(CMS_INDIRECT, 8'h10, 8'h77, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h10, 8'h00, 8'h77, 2'h2);
        add(CMS_DIRECT, 8'h21, 8'h00, 8'h00, 2'h1);
        add(CMS_BIT, 8'h0B, 8'h01, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h21, 8'h00, 8'h08, 2'h2);
        add(CMS_BIT, 8'h0B, 8'h00, 8'h01, 2'h2);
        add(CMS_BANK_REG, 8'h03, 8'h66, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h03, 8'h00, 8'h66, 2'h2);
        add(CMS_DIRECT, 8'hD0, 8'h08, 8'h00, 2'h3);
        add(CMS_BANK_REG, 8'h03, 8'h99, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h0B, 8'h00, 8'h99, 2'h2);
        add(CMS_DIRECT, 8'hD0, 8'h00, 8'h08, 2'h3);
        add(CMS_DIRECT, 8'h81, 8'h00, 8'h07, 2'h2);
        add(CMS_PUSH, 8'h00, 8'hAA, 8'h00, 2'h1);
        add(CMS_DIRECT, 8'h08, 8'h00, 8'hAA, 2'h2);
        add(CMS_POP, 8'h00, 8'h00, 8'hAA, 2'h2);
        add(CMS_DIRECT, 8'h81, 8'h00, 8'h07, 2'h2);
        add(CMS_DIRECT, 8'hF0, 8'h12, 8'h00, 2'h3);
        add(CMS_DIRECT, 8'hF0, 8'h00, 8'h12, 2'h2);
        add(CMS_DIRECT, 8'hE0, 8'h34, 8'h00, 2'h3);
        add(CMS_DIRECT, 8'hB0, 8'h00, 8'h14, 2'h2);
        add(CMS_DIRECT, 8'hB0, 8'hFD, 8'h14, 2'h3);
        repeat (20) @(negedge core_clk);
        rst = 1'h0;
        foreach (rows[k]) begin
            access(rows[k], q, v);
            check(v, 1'h1);
            if (rows[k].flags[1]) begin
                check(q, rows[k].exp);
            end
        end
        check(main_work_value, 8'h34);
        check(port_oe, 8'h02);
        check(port_out, 8'h00);
        alt_out = 8'hFE;
        aux_load = 1'h1;
        aux_load_data = 8'h5C;
        @(negedge core_clk);
        aux_load = 1'h0;
        repeat (4) @(negedge core_clk);
        check(aux_value, 8'h5C);
        check(port_oe, 8'h03);
        check({tm1, tm0, irq1, irq0, ser}, 5'h0A);
        strobe_run(16'h0100, 1'h0, 1'h0, 16'h0000);
        strobe_run(16'h1FFF, 1'h0, 1'h0, 16'h0000);
        strobe_run(16'h2000, 1'h0, 1'h0, 16'h0008);
        check(low_len, 4'h3);
        strobe_run(16'h0100, 1'h0, 1'h1, 16'h0008);
        strobe_run(16'h2000, 1'h1, 1'h0, 16'h0000);
        access('{CMS_DIRECT, 8'h81, 8'h40, 8'h00, 2'h1}, q, v);
        access('{CMS_DIRECT, 8'hD0, 8'h18, 8'h00, 2'h1}, q, v);
        check(active_bank, 2'h3);
        v = 1'h0;
        reset_pin = 1'h1;
        for (i = 0; i < 12; i++) begin
            @(negedge core_clk);
            v = v | core_reset;
        end
        reset_pin = 1'h0;
        check(v, 1'h0);
        repeat (6) @(negedge core_clk);
        reset_pin = 1'h1;
        for (i = 0; i < 40 && core_reset !== 1'h1; i++) begin
            @(negedge core_clk);
        end
        if (core_reset !== 1'h1) begin
            bad_count++;
            close_out();
        end
        check(i > 22, 1'h1);
        access('{CMS_DIRECT, 8'h30, 8'h00, 8'h00, 2'h2}, q, v);
        check(v, 1'h0);
        check(stack_pointer, 8'h07);
        check(active_bank, 2'h0);
        reset_pin = 1'h0;
        repeat (6) @(negedge core_clk);
        check(core_reset, 1'h0);
        close_out();
    end
endmodule
